// ===== logic/acs_adc_seq.sv
// converter sequencing, result latching and register slave
//
// Behaviour
// - A series started by any trigger may give a wrong first sample, so that sample is marked unless the sample-after-convert bit is set.
// - With the sample-after-convert bit set, sampling starts only once all conversions end.
// - Conversion takes exactly 13 converter clocks after the sampling phase ends.
// - The result is handed off on cycle 14 after sampling and written to its slot on cycle 15.
// - Sampling that ends on another conversion's cycle 14 leaves that result not assured.
// - The sample-after-convert bit is bit 1 of control two, and with it no clash can occur.
// - Back to back with window 6, each sampling phase ends on cycle 13 of the running one.
`timescale 1ns/1ps

module acs_adc_seq
  import acs_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // register bus
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  // triggers
  input  wire logic          trigIn,
  // analog core
  input  wire acs_core_in_t  coreIn,
  output acs_core_out_t      coreOut
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] lowestSlot(input logic [3:0] mask);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = NUM_SLOT - 1; i >= 0; i--) begin
      if (mask[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction : lowestSlot

  function automatic logic isReg(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : isReg

  acs_state_t st;
  acs_state_t next_st;

  logic       addrPhase;
  logic       anyBusy;
  logic       allFree;
  logic       overlapOk;
  logic       sampEnd;
  logic       trkFound;
  logic [1:0] freeIdx;
  logic [7:0] rdAddr;
  logic [31:0] rdVal;

  assign addrPhase = hsel & htrans[1] & hready;
  assign rdAddr    = haddr[7:0];

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdVal = RST_RDATA;
    if (isReg(rdAddr, OFS_CTRL_TWO)) begin
      rdVal[BIT_SIMUL_MODE]   = st.simulMode;
      rdVal[BIT_SAMPLE_AFTER] = st.nonOverlap;
    end else if (isReg(rdAddr, OFS_ACQ)) begin
      rdVal[5:0] = st.acqLen;
    end else if (isReg(rdAddr, OFS_SERIES)) begin
      rdVal[3:0] = st.seriesMask;
    end else if (isReg(rdAddr, OFS_STATUS)) begin
      rdVal[BIT_ST_BUSY]                  = anyBusy;
      rdVal[BIT_ST_CLASH]                 = st.clash;
      rdVal[POS_ST_SUSPECT +: NUM_SLOT]   = st.suspect;
    end else begin
      for (int s = 0; s < NUM_SLOT; s++) begin
        if (isReg(rdAddr, OFS_RESULT0 + 8'(4 * s))) begin
          rdVal = {4'h0, st.results[s][23:12], 4'h0, st.results[s][11:0]};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // tracker status
  // ---------------------------------------------------------------
  always_comb begin
    allFree   = 1'b1;
    overlapOk = 1'b1;
    trkFound  = 1'b0;
    freeIdx   = 2'h0;
    for (int t = 0; t < NUM_TRK; t++) begin
      if (st.trk[t].cnt != 4'h0) begin
        allFree = 1'b0;
        if (st.trk[t].cnt < OVL_START_CYC) begin
          overlapOk = 1'b0;
        end
      end else if (!trkFound) begin
        trkFound = 1'b1;
        freeIdx  = 2'(t);
      end
    end
    overlapOk = overlapOk & trkFound;
  end

  assign anyBusy = (st.pending != 4'h0) | st.sampling | ~allFree;
  assign sampEnd = st.sampling & (st.sampCnt == st.acqLen);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic        trigger;
    logic        canStart;
    logic [31:0] wd;
    next_st  = st;
    trigger  = trigIn;
    canStart = 1'b0;
    wd       = hwdata;

    // register writes in the data phase
    if (st.wrPend) begin
      if (isReg(st.wrAddr, OFS_CTRL_TWO)) begin
        next_st.nonOverlap = wd[BIT_SAMPLE_AFTER];
        next_st.simulMode  = wd[BIT_SIMUL_MODE];
      end
      if (isReg(st.wrAddr, OFS_ACQ)) begin
        next_st.acqLen = wd[5:0];
      end
      if (isReg(st.wrAddr, OFS_SERIES)) begin
        next_st.seriesMask = wd[3:0];
      end
      if (isReg(st.wrAddr, OFS_TRIGGER)) begin
        trigger = trigger | wd[BIT_TRIG_GO];
      end
      if (isReg(st.wrAddr, OFS_STATUS)) begin
        next_st.clash   = st.clash & ~wd[BIT_ST_CLASH];
        next_st.suspect = st.suspect & ~wd[POS_ST_SUSPECT +: NUM_SLOT];
      end
    end

    // a trigger queues the whole series
    if (trigger) begin
      next_st.pending     = next_st.pending | st.seriesMask;
      next_st.seriesFirst = 1'b1;
    end

    // conversion trackers
    for (int t = 0; t < NUM_TRK; t++) begin
      if (st.trk[t].cnt != 4'h0) begin
        next_st.trk[t].cnt = (st.trk[t].cnt == LATCH_CYCLE) ? 4'h0 : st.trk[t].cnt + 4'h1;
      end
      if (st.trk[t].cnt == HANDOFF_CYCLE) begin
        next_st.trk[t].data = {coreIn.resultB, coreIn.resultA};
        if (sampEnd) begin
          next_st.trk[t].clash = 1'b1;
          next_st.clash        = 1'b1;
        end
      end
      if (st.trk[t].cnt == LATCH_CYCLE) begin
        next_st.results[st.trk[t].slot] = st.trk[t].data;
        if (st.trk[t].first | st.trk[t].clash) begin
          next_st.suspect[st.trk[t].slot] = 1'b1;
        end
      end
    end

    // end of sampling starts a conversion
    if (sampEnd) begin
      next_st.sampling                  = 1'b0;
      next_st.trk[freeIdx].cnt          = 4'h1;
      next_st.trk[freeIdx].slot         = st.sampSlot;
      next_st.trk[freeIdx].first        = st.sampFirst & ~st.nonOverlap;
      next_st.trk[freeIdx].clash        = 1'b0;
    end else if (st.sampling) begin
      next_st.sampCnt = st.sampCnt + 6'h01;
    end

    if (st.nonOverlap) begin
      canStart = allFree;
    end else begin
      canStart = overlapOk;
    end

    if (!st.sampling && (st.pending != 4'h0) && canStart) begin
      next_st.sampling                       = 1'b1;
      next_st.sampCnt                        = 6'h00;
      next_st.sampSlot                       = lowestSlot(st.pending);
      next_st.sampFirst                      = st.seriesFirst;
      next_st.seriesFirst                    = trigger;
      next_st.pending[lowestSlot(st.pending)] = trigger & st.seriesMask[lowestSlot(st.pending)];
    end

    // bus address phase
    next_st.wrPend   = addrPhase & hwrite;
    next_st.wrAddr   = rdAddr;
    next_st.readyOut = 1'b1;
    if (addrPhase && !hwrite) begin
      next_st.rdata = rdVal;
    end

    // core-facing outputs
    next_st.core.sampleEn    = next_st.sampling;
    next_st.core.sampleSlot  = next_st.sampSlot;
    next_st.core.simulMode   = next_st.simulMode;
    next_st.core.handoff     = 1'b0;
    next_st.core.handoffSlot = st.core.handoffSlot;
    for (int t = 0; t < NUM_TRK; t++) begin
      if (next_st.trk[t].cnt == HANDOFF_CYCLE) begin
        next_st.core.handoff     = 1'b1;
        next_st.core.handoffSlot = next_st.trk[t].slot;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st            <= '0;
      st.acqLen     <= RST_ACQ;
      st.seriesMask <= RST_SERIES;
      st.rdata      <= RST_RDATA;
      st.readyOut   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hreadyout = st.readyOut;
  assign hrdata    = st.rdata;
  assign hresp     = 1'b0;
  assign coreOut   = st.core;

endmodule : acs_adc_seq

// ===== logic/acs_pkg.sv
// constants and carrier types of the converter sequencing block
package acs_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_TWO = 8'h00;
  localparam logic [7:0] OFS_ACQ      = 8'h04;
  localparam logic [7:0] OFS_SERIES   = 8'h08;
  localparam logic [7:0] OFS_TRIGGER  = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_RESULT0  = 8'h20;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_SIMUL_MODE   = 0;
  localparam int BIT_SAMPLE_AFTER = 1;
  localparam int BIT_TRIG_GO      = 0;
  localparam int BIT_ST_BUSY      = 0;
  localparam int BIT_ST_CLASH     = 1;
  localparam int POS_ST_SUSPECT   = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [5:0]  RST_ACQ    = 6'h00;
  localparam logic [3:0]  RST_SERIES = 4'h1;
  localparam logic [31:0] RST_RDATA  = 32'h0000_0000;

  // ---------------------------------------------------------------
  // timing counts in converter clocks after sampling ends, and the tracker and slot counts
  // ---------------------------------------------------------------
  localparam logic [3:0] CONV_CYCLES   = 4'h0_d;
  localparam logic [3:0] HANDOFF_CYCLE = 4'h0_e;
  localparam logic [3:0] LATCH_CYCLE   = 4'h0_f;
  localparam logic [3:0] OVL_START_CYC = 4'h0_6;
  localparam int         NUM_TRK       = 3;
  localparam int         NUM_SLOT      = 4;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] resultA;
    logic [11:0] resultB;
  } acs_core_in_t;

  typedef struct packed {
    logic       sampleEn;
    logic [1:0] sampleSlot;
    logic       simulMode;
    logic       handoff;
    logic [1:0] handoffSlot;
  } acs_core_out_t;

  typedef struct packed {
    logic [3:0]  cnt;
    logic [1:0]  slot;
    logic        first;
    logic        clash;
    logic [23:0] data;
  } acs_trk_t;

  typedef struct packed {
    logic                        nonOverlap;
    logic                        simulMode;
    logic [5:0]                  acqLen;
    logic [3:0]                  seriesMask;
    logic [3:0]                  pending;
    logic                        seriesFirst;
    logic                        sampling;
    logic [5:0]                  sampCnt;
    logic [1:0]                  sampSlot;
    logic                        sampFirst;
    acs_trk_t [NUM_TRK-1:0]      trk;
    logic                        clash;
    logic [3:0]                  suspect;
    logic [NUM_SLOT-1:0][23:0]   results;
    logic                        wrPend;
    logic [7:0]                  wrAddr;
    logic [31:0]                 rdata;
    logic                        readyOut;
    acs_core_out_t               core;
  } acs_state_t;

endpackage : acs_pkg

// ===== bench/acs_chk.sv
// assertion checker of the sequencing block
`timescale 1ns/1ps
module acs_chk
  import acs_pkg::*;
(
  // bus and core link
  input wire logic          clk,
  input wire logic          rst_b,
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic          hready,
  input wire logic [31:0]   hwdata,
  input wire acs_core_out_t coreOut
);
  logic       wAct;
  logic       nonOv;
  logic [7:0] wAdr;
  logic [5:0] acq;
  logic [6:0] run;
  logic [1:0] inFl;
  // shadow of the sample-after-convert bit, sampling length, conversions in flight
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {wAct, nonOv, wAdr, acq, run, inFl} <= '0;
    end else begin
      wAct <= hsel & htrans[1] & hready & hwrite;
      wAdr <= haddr[7:0];
      if (wAct && wAdr == OFS_CTRL_TWO) nonOv <= hwdata[BIT_SAMPLE_AFTER];
      if (wAct && wAdr == OFS_ACQ) acq <= hwdata[5:0];
      if (coreOut.sampleEn) run <= $rose(coreOut.sampleEn) ? 7'h01 : run + 7'h01;
      inFl <= inFl + 2'($fell(coreOut.sampleEn)) - 2'(coreOut.handoff);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_end; $fell(coreOut.sampleEn); endsequence
  sequence s_hand; ##13 coreOut.handoff; endsequence
  property p_lat;
    s_end |-> s_hand ##0 (coreOut.handoffSlot == $past(coreOut.sampleSlot, 14));
  endproperty
  a_lat: assert property (p_lat) else $error("hand-off latency wrong");
  property p_pulse; coreOut.handoff |=> !coreOut.handoff; endproperty
  a_pulse: assert property (p_pulse) else $error("hand-off not one cycle");
  property p_slot; !coreOut.handoff |-> $stable(coreOut.handoffSlot); endproperty
  a_slot: assert property (p_slot) else $error("hand-off slot moved");
  property p_win; s_end |-> run == 7'(acq) + 7'h01; endproperty
  a_win: assert property (p_win) else $error("sampling length wrong");
  property p_nonov; $rose(coreOut.sampleEn) && nonOv |-> inFl == 2'h0; endproperty
  a_nonov: assert property (p_nonov) else $error("sampling during conversion");
  property p_ncl; s_end ##0 nonOv |-> !$past(coreOut.handoff); endproperty
  a_ncl: assert property (p_ncl) else $error("clash with bit set");
  property p_six; s_end ##0 (acq == 6'h06 && !nonOv && inFl != 2'h0) |-> coreOut.handoff; endproperty
  a_six: assert property (p_six) else $error("window six end not on cycle 13");
endmodule : acs_chk

bind acs_adc_seq acs_chk u_chk (
  .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .coreOut(coreOut));

// ===== bench/acs_core_model.sv
// behavioural model of the analog sample and convert core
`timescale 1ns/1ps
module acs_core_model
  import acs_pkg::*;
(
  // clock and data base
  input  wire logic          clk,
  input  wire logic [11:0]   seed,
  // core link
  input  wire acs_core_out_t coreOut,
  output acs_core_in_t       coreIn
);
  logic [11:0] nConv = '0;
  logic [11:0] cyc   = '0;
  logic [11:0] val;
  assign val = seed + nConv * 12'h025;
  always @(posedge clk) begin
    cyc <= cyc + 12'h001;
    if (coreOut.handoff) nConv <= nConv + 12'h001;
  end
  // data valid only in hand-off cycle
  always_comb coreIn = coreOut.handoff ? {val, ~val} : {cyc, ~cyc};
endmodule : acs_core_model

// ===== bench/acs_adc_seq_tb.sv
// self-checking bench of the sequencing block
`timescale 1ns/1ps
module acs_adc_seq_tb
  import acs_pkg::*;
();
  localparam logic [1:0] T_CTL [5] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h3};
  localparam logic [5:0] T_ACQ [5] = '{6'h08, 6'h07, 6'h06, 6'h07, 6'h00};
  logic          clk, rst_b, hsel, hwrite, trigIn, hreadyout, hresp, clash;
  logic [31:0]   haddr, hwdata, hrdata, rd, expv;
  logic [1:0]    htrans;
  logic [11:0]   seed, a;
  logic [5:0]    acq;
  acs_core_in_t  coreIn;
  acs_core_out_t coreOut;
  int            n_mismatch = 0;
  int            check_count = 0;
  int            cycles = 0;
  int            nConv = 0;

  acs_adc_seq dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .trigIn(trigIn),
    .coreIn(coreIn), .coreOut(coreOut));
  acs_core_model core (.clk(clk), .seed(seed), .coreOut(coreOut), .coreIn(coreIn));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, ad};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check_count++;
    if (hresp !== 1'b0) begin
      n_mismatch++;
      $display("Error at %0t: response not okay", $time);
    end
  endtask : bus

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk

  initial begin
    {hsel, hwrite, trigIn, htrans, haddr, hwdata} = '0;
    seed = 12'($urandom(32'h0000_f4dc));
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, OFS_SERIES, '0);
    chk(rd, 32'(RST_SERIES));
    bus(1'b0, OFS_ACQ, '0);
    chk(rd, 32'(RST_ACQ));
    bus(1'b0, 8'h30, '0);
    chk(rd, RST_RDATA);
    for (int i = 0; i < 5; i++) begin
      acq = T_ACQ[i] + ((i == 0) ? 6'($urandom_range(12, 0)) : 6'h00);
      if (i == 4) acq = 6'($urandom_range(63, 0));
      clash = !T_CTL[i][1] && acq == 6'h07;
      bus(1'b1, OFS_CTRL_TWO, 32'(T_CTL[i]));
      bus(1'b1, OFS_ACQ, 32'(acq));
      chk(32'(coreOut.simulMode), 32'(T_CTL[i][0]));
      bus(1'b1, OFS_SERIES, 32'h0000_000f);
      if (i[0]) begin
        bus(1'b1, OFS_TRIGGER, 32'h0000_0001);
      end else begin
        @(posedge clk) trigIn <= 1'b1;
        @(posedge clk) trigIn <= 1'b0;
      end
      do bus(1'b0, OFS_STATUS, '0); while (rd[BIT_ST_BUSY] !== 1'b0);
      // first A and B of a series marked for dropping only with the sample-after-convert bit clear
      chk(32'(rd[POS_ST_SUSPECT]), 32'(!T_CTL[i][1]));
      chk(32'(rd[BIT_ST_CLASH]), 32'(clash));
      for (int k = 0; k < 4; k++) begin
        a = seed + 12'(nConv) * 12'h025;
        nConv++;
        bus(1'b0, OFS_RESULT0 + 8'(k * 4), '0);
        expv = T_CTL[i][0] ? {4'h0, ~a, 4'h0, a} : {20'h0_0000, a};
        if (!clash) chk(rd & (T_CTL[i][0] ? 32'h0fff_0fff : 32'h0000_0fff), expv);
      end
      bus(1'b1, OFS_STATUS, 32'h0000_00f2);
      bus(1'b0, OFS_STATUS, '0);
      chk(rd, RST_RDATA);
    end
    report_and_stop();
  end
endmodule : acs_adc_seq_tb
